// File: verilog/rdd_pkg.sv
// Purpose: Shared constants and carriers for the rail disable and discharge register bank.
// Assumes: Byte-wide registers behind an internal register port fed by the serial host engine.
// Notes:   Factory-programmed reset values arrive as straps and are caught after reset.
package rdd_pkg;

    // Register offsets.
    localparam logic [7:0] OFS_LINEAR_A2_CONTROL   = 8'h28;
    localparam logic [7:0] OFS_LINEAR_A3_CONTROL   = 8'h29;
    localparam logic [7:0] OFS_DISCHARGE_SEL_ONE   = 8'h40;
    localparam logic [7:0] OFS_DISCHARGE_SEL_TWO   = 8'h41;
    localparam logic [7:0] OFS_DISCHARGE_SEL_THREE = 8'h42;

    // Field layout.
    localparam int          ENABLE_BIT      = 0;
    localparam int          RSVD_LO         = 2;
    localparam int          RSVD_HI         = 5;
    localparam int          NUM_RAILS       = 12;
    localparam int          FIELD_W         = 2;
    localparam logic [7:0]  CTRL_RW_MASK    = 8'h3F;
    localparam logic [7:0]  DISCH3_RW_MASK  = 8'h3F;
    localparam logic [3:0]  RSVD_RESET      = 4'hF;
    localparam logic [1:0]  NO_DISCHARGE    = 2'h0;

    // Rail indices into the twelve discharge fields, in register order.
    localparam int RAIL_BUCK1  = 0;
    localparam int RAIL_BUCK2  = 1;
    localparam int RAIL_BUCK3  = 2;
    localparam int RAIL_BUCK4  = 3;
    localparam int RAIL_BUCK5  = 4;
    localparam int RAIL_BUCK6  = 5;
    localparam int RAIL_SW_A1  = 6;
    localparam int RAIL_LIN_A2 = 7;
    localparam int RAIL_LIN_A3 = 8;
    localparam int RAIL_SW_B1  = 9;
    localparam int RAIL_SW_B2  = 10;

    typedef enum logic [1:0] {
        DIS_NONE = 2'b00,
        DIS_100R = 2'b01,
        DIS_200R = 2'b10,
        DIS_500R = 2'b11
    } rdd_dis_e;

    // One-hot resistor selection handed to a rail's discharge circuit.
    typedef struct packed {
        logic r500;
        logic r200;
        logic r100;
    } rdd_dis_sel_s;

    // Register port request.
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rdd_req_s;

endpackage

// File: verilog/rdd_ctrl_reg.sv
// Purpose: One linear regulator control register with enable bit and writable reserved bits that reset to ones.
// Assumes: Write strobe already decoded to this register.
// Notes:   Reset value of the enable bit is loaded from a strap one cycle after reset.
`timescale 1ns/100ps
module rdd_ctrl_reg
(
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       srst_i,
    // Factory default of the enable bit
    input  wire logic       strap_en_i,
    // Decoded write
    input  wire logic       wr_i,
    input  wire logic [7:0] wdata_i,
    // Register value and pin gating
    input  wire logic       pin_req_i,
    output logic      [7:0] rdata_o,
    output logic            rail_on_o
);

    logic       load_ff;
    logic       nxt_load;
    logic [5:0] val_ff;
    logic [5:0] nxt_val;

    always_comb
    begin
        nxt_load = 1'b0;
        nxt_val  = val_ff;
        if (load_ff)
        begin
            nxt_val[rdd_pkg::ENABLE_BIT] = strap_en_i;
        end
        else if (wr_i)
        begin
            // Only the low six bits are stored; the top two cannot be disturbed.
            nxt_val = wdata_i[5:0];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            load_ff <= 1'b1;
            val_ff  <= {rdd_pkg::RSVD_RESET, 2'h0};
        end
        else
        begin
            load_ff <= nxt_load;
            val_ff  <= nxt_val;
        end
    end

    assign rdata_o   = {2'h0, val_ff} & rdd_pkg::CTRL_RW_MASK;
    // A cleared enable bit overrides whatever the control input pins ask for.
    assign rail_on_o = pin_req_i & val_ff[rdd_pkg::ENABLE_BIT];

    a_enable_gates_pin: assert property (@(posedge clk_i) disable iff (srst_i)
        !val_ff[rdd_pkg::ENABLE_BIT] |-> !rail_on_o)
        else $error("Rail on while enable bit is clear.");

endmodule

// File: verilog/rdd_regs.sv
// Purpose: Linear regulator control registers and twelve rail discharge selections.
// Assumes: The serial host engine presents one-cycle byte reads and writes on the register port.
// Notes:   Discharge fields are cleared in storage while their rail is enabled.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////////////////////////
// Function
// - A3 control at 0x29, enable, reserved ones
// - Cleared enable bit keeps A3 off
// - Decode discharge codes to resistor selections
// - Enabled rail forces its field to 00
// - Discharge register one at 0x40, bucks 1-4
// - Discharge register two at 0x41
// - Discharge register three at 0x42, top zero
// - A2 control at 0x28 behaves like A3
module rdd_regs
(
    // Clock and reset
    input  wire logic                                      clk_i,
    input  wire logic                                      srst_i,
    // Register port
    input  wire rdd_pkg::rdd_req_s                         req_i,
    input  wire logic                                      req_valid_i,
    output logic      [7:0]                                rdata_o,
    output logic                                           rdata_valid_o,
    // Factory defaults
    input  wire logic                                      strap_a2_en_i,
    input  wire logic                                      strap_a3_en_i,
    input  wire logic [rdd_pkg::NUM_RAILS*rdd_pkg::FIELD_W-1:0] strap_disch_i,
    // Rail enables and pin requests
    input  wire logic                                      lin_a2_pin_req_i,
    input  wire logic                                      lin_a3_pin_req_i,
    input  wire logic [rdd_pkg::NUM_RAILS-1:0]             rail_enabled_i,
    output logic                                           lin_a2_on_o,
    output logic                                           lin_a3_on_o,
    // Discharge selections
    output rdd_pkg::rdd_dis_sel_s [rdd_pkg::NUM_RAILS-1:0] disch_sel_o
);

    localparam int DW = rdd_pkg::NUM_RAILS * rdd_pkg::FIELD_W;

    function automatic rdd_pkg::rdd_dis_sel_s decode_disch(input logic [1:0] code);
        rdd_pkg::rdd_dis_sel_s s;
        s = '0;
        // A plain case keeps an unknown code quiet before the first reset edge.
        case (rdd_pkg::rdd_dis_e'(code))
            rdd_pkg::DIS_NONE: s = '0;
            rdd_pkg::DIS_100R: s.r100 = 1'b1;
            rdd_pkg::DIS_200R: s.r200 = 1'b1;
            rdd_pkg::DIS_500R: s.r500 = 1'b1;
        endcase
        return s;
    endfunction

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Control registers.

    logic       wr_a2;
    logic       wr_a3;
    logic [7:0] a2_rdata;
    logic [7:0] a3_rdata;

    assign wr_a2 = req_valid_i & req_i.wr & (req_i.addr == rdd_pkg::OFS_LINEAR_A2_CONTROL);
    assign wr_a3 = req_valid_i & req_i.wr & (req_i.addr == rdd_pkg::OFS_LINEAR_A3_CONTROL);

    rdd_ctrl_reg u_a2
    (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .strap_en_i (strap_a2_en_i),
        .wr_i       (wr_a2),
        .wdata_i    (req_i.wdata),
        .pin_req_i  (lin_a2_pin_req_i),
        .rdata_o    (a2_rdata),
        .rail_on_o  (lin_a2_on_o)
    );

    rdd_ctrl_reg u_a3
    (
        .clk_i      (clk_i),
        .srst_i     (srst_i),
        .strap_en_i (strap_a3_en_i),
        .wr_i       (wr_a3),
        .wdata_i    (req_i.wdata),
        .pin_req_i  (lin_a3_pin_req_i),
        .rdata_o    (a3_rdata),
        .rail_on_o  (lin_a3_on_o)
    );

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Discharge fields, stored flat: rail k lives in bits 2k+1:2k.

    logic          load_ff;
    logic          nxt_load;
    logic [DW-1:0] disch_ff;
    logic [DW-1:0] nxt_disch;
    logic [DW-1:0] wr_val;
    logic [DW-1:0] wr_mask;

    // Selections are registered from the next field values, so they move on the same edge.
    rdd_pkg::rdd_dis_sel_s [rdd_pkg::NUM_RAILS-1:0] sel_ff;
    rdd_pkg::rdd_dis_sel_s [rdd_pkg::NUM_RAILS-1:0] nxt_sel;

    always_comb
    begin
        wr_val  = {req_i.wdata, req_i.wdata, req_i.wdata};
        wr_mask = '0;
        if (req_valid_i && req_i.wr)
        begin
            unique case (req_i.addr)
                rdd_pkg::OFS_DISCHARGE_SEL_ONE:   wr_mask[7:0]   = 8'hFF;
                rdd_pkg::OFS_DISCHARGE_SEL_TWO:   wr_mask[15:8]  = 8'hFF;
                rdd_pkg::OFS_DISCHARGE_SEL_THREE: wr_mask[23:16] = rdd_pkg::DISCH3_RW_MASK;
                default:                          wr_mask = '0;
            endcase
        end
    end

    always_comb
    begin
        nxt_load  = 1'b0;
        nxt_disch = load_ff ? strap_disch_i : ((disch_ff & ~wr_mask) | (wr_val & wr_mask));
        // Clearing after the write merge lets the rail enable win over a host write.
        for (int k = 0; k < rdd_pkg::NUM_RAILS; k++)
        begin
            if (rail_enabled_i[k])
            begin
                nxt_disch[k*2 +: 2] = rdd_pkg::NO_DISCHARGE;
            end
        end
        nxt_disch[DW-1 -: 2] = 2'h0;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            load_ff  <= 1'b1;
            disch_ff <= '0;
            sel_ff   <= '0;
        end
        else
        begin
            load_ff  <= nxt_load;
            disch_ff <= nxt_disch;
            sel_ff   <= nxt_sel;
        end
    end

    genvar g;
    generate
        for (g = 0; g < rdd_pkg::NUM_RAILS; g++)
        begin : g_dec
            assign nxt_sel[g] = decode_disch(nxt_disch[g*2 +: 2]);
        end
    endgenerate

    assign disch_sel_o = sel_ff;

    //////////////////////////////////////////////////////////////////////////////////////////////
    // Read path: data registered one cycle after the request; unmapped reads return zero.

    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic       rvalid_ff;
    logic       nxt_rvalid;

    always_comb
    begin
        nxt_rvalid = req_valid_i & ~req_i.wr;
        unique case (req_i.addr)
            rdd_pkg::OFS_LINEAR_A2_CONTROL:   nxt_rdata = a2_rdata;
            rdd_pkg::OFS_LINEAR_A3_CONTROL:   nxt_rdata = a3_rdata;
            rdd_pkg::OFS_DISCHARGE_SEL_ONE:   nxt_rdata = disch_ff[7:0];
            rdd_pkg::OFS_DISCHARGE_SEL_TWO:   nxt_rdata = disch_ff[15:8];
            rdd_pkg::OFS_DISCHARGE_SEL_THREE: nxt_rdata = disch_ff[23:16] & rdd_pkg::DISCH3_RW_MASK;
            default:                          nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            rdata_ff  <= 8'h00;
            rvalid_ff <= 1'b0;
        end
        else
        begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    assign rdata_o       = rdata_ff;
    assign rdata_valid_o = rvalid_ff;

    //////////////////////////////////////////////////////////////////////////////////////////////

    a_enabled_rail_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        rail_enabled_i[rdd_pkg::RAIL_BUCK3] |=> disch_ff[5:4] == 2'b00)
        else $error("Enabled rail kept a discharge code.");

    a_a3_field_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        rail_enabled_i[rdd_pkg::RAIL_LIN_A3] |=> disch_sel_o[rdd_pkg::RAIL_LIN_A3] == '0)
        else $error("Linear A3 discharge active while enabled.");

    a_decode_500: assert property (@(posedge clk_i) disable iff (srst_i)
        disch_ff[1:0] == 2'b11 |-> disch_sel_o[rdd_pkg::RAIL_BUCK1] == 3'b100)
        else $error("Code 11 did not select 500 ohm.");

    a_write_one: assert property (@(posedge clk_i) disable iff (srst_i)
        req_valid_i && req_i.wr && req_i.addr == rdd_pkg::OFS_DISCHARGE_SEL_ONE
        && !load_ff && rail_enabled_i[3:0] == 4'h0 |=> disch_ff[7:0] == $past(req_i.wdata))
        else $error("Discharge register one write lost.");

    a_write_two: assert property (@(posedge clk_i) disable iff (srst_i)
        req_valid_i && req_i.wr && req_i.addr == rdd_pkg::OFS_DISCHARGE_SEL_TWO
        && !load_ff && rail_enabled_i[7:4] == 4'h0 |=> disch_ff[15:8] == $past(req_i.wdata))
        else $error("Discharge register two write lost.");

    a_three_top_zero: assert property (@(posedge clk_i) disable iff (srst_i)
        rdata_valid_o && $past(req_i.addr) == rdd_pkg::OFS_DISCHARGE_SEL_THREE
        |-> rdata_o[7:6] == 2'b00)
        else $error("Read-only bits of register three not zero.");

    a_ctrl_top_zero: assert property (@(posedge clk_i) disable iff (srst_i)
        a3_rdata[7:6] == 2'b00 && a2_rdata[7:6] == 2'b00)
        else $error("Control register top bits not zero.");

    a_a3_reserved_reset: assert property (@(posedge clk_i)
        $fell(srst_i) |-> a3_rdata[rdd_pkg::RSVD_HI:rdd_pkg::RSVD_LO] == 4'hF)
        else $error("A3 reserved bits not one after reset.");

    a_a2_gate: assert property (@(posedge clk_i) disable iff (srst_i)
        !a2_rdata[rdd_pkg::ENABLE_BIT] |-> !lin_a2_on_o)
        else $error("Linear A2 on while enable bit clear.");

endmodule

// File: bench/rdd_host_model.sv
// Purpose: Serial host stand-in issuing byte accesses on the register port.
// Assumes: Callers enter each access at a falling clock edge.
// Notes:   A released port shows inverted data so stale values cannot pass.
`timescale 1ns/100ps
module rdd_host_model
(
    // Clock
    input  wire logic              clk_i,
    // Register port
    output rdd_pkg::rdd_req_s      req_o,
    output logic                   req_valid_o,
    input  wire logic [7:0]        rdata_i,
    input  wire logic              rdata_valid_i
);
    initial
    begin
        req_o       = '0;
        req_valid_o = 1'b0;
    end

    task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d,
                          output logic [7:0] r, output logic v);
        logic [7:0] wd;
        wd = d;
        if (w && a[7:1] == 7'h14)
            wd[5:2] = 4'hF;
        req_o       = '{wr: w, addr: a, wdata: wd};
        req_valid_o = 1'b1;
        @(negedge clk_i);
        r = rdata_i;
        v = rdata_valid_i;
    endtask

    task automatic idle();
        req_valid_o = 1'b0;
        req_o       = ~req_o;
        @(negedge clk_i);
    endtask
endmodule

// File: bench/tb_rdd_regs.sv
// Purpose: Self-checking bench for the rail disable and discharge register bank.
// Assumes: Straps are random per reset and caught on the first edge after release.
// Notes:   A reference model of both control registers and the eleven rail fields is compared after every access.
`timescale 1ns/100ps
module tb_rdd_regs;
    logic                                   clk_i  = 1'b0;
    logic                                   srst_i = 1'b1;
    rdd_pkg::rdd_req_s                      req;
    logic                                   req_valid;
    logic                                   rvalid;
    logic [7:0]                             rdata;
    logic [1:0]                             st_en;
    logic [23:0]                            straps;
    logic [1:0]                             pins;
    logic [1:0]                             on;
    logic [11:0]                            rails;
    rdd_pkg::rdd_dis_sel_s [11:0]           sel;
    logic [7:0]                             ctl [2];
    logic [1:0]                             fld [11];
    logic [7:0]                             addrs [7] = '{8'h27, 8'h28, 8'h29, 8'h40,
                                                          8'h41, 8'h42, 8'h43};
    int                                     fail_count = 0;
    int                                     tests_run  = 0;
    int                                     cycles     = 0;

    always #12.5 clk_i = ~clk_i;

    rdd_host_model u_rdd_host_model
    (
        .clk_i(clk_i), .req_o(req), .req_valid_o(req_valid),
        .rdata_i(rdata), .rdata_valid_i(rvalid)
    );

    rdd_regs u_rdd_regs
    (
        .clk_i(clk_i), .srst_i(srst_i), .req_i(req), .req_valid_i(req_valid),
        .rdata_o(rdata), .rdata_valid_o(rvalid), .strap_a2_en_i(st_en[0]),
        .strap_a3_en_i(st_en[1]), .strap_disch_i(straps), .lin_a2_pin_req_i(pins[0]),
        .lin_a3_pin_req_i(pins[1]), .rail_enabled_i(rails), .lin_a2_on_o(on[0]),
        .lin_a3_on_o(on[1]), .disch_sel_o(sel)
    );

    ////////////////////////////////////////////////////////////////////////////////
    function automatic void clr();
        for (int k = 0; k < 11; k++)
            if (rails[k])
                fld[k] = 2'h0;
    endfunction

    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == 8'h28 || a == 8'h29)
            v = ctl[a[0]];
        if (a >= 8'h40 && a <= 8'h42)
            for (int j = 0; j < 4; j++)
                if (4 * (a - 8'h40) + j < 11)
                    v[2*j +: 2] = fld[4 * (a - 8'h40) + j];
        return v;
    endfunction

    function automatic void mdl_wr(input logic [7:0] a, input logic [7:0] d);
        if (a == 8'h28 || a == 8'h29)
            ctl[a[0]] = d & 8'h3F;
        if (a >= 8'h40 && a <= 8'h42)
            for (int j = 0; j < 4; j++)
                if (4 * (a - 8'h40) + j < 11)
                    fld[4 * (a - 8'h40) + j] = d[2*j +: 2];
        clr();
    endfunction

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_out();
        logic [2:0] e;
        for (int i = 0; i < 2; i++)
            chk("lin_on", {7'h00, pins[i] & ctl[i][0]}, {7'h00, on[i]});
        for (int k = 0; k < 11; k++)
        begin
            e = (fld[k] == 2'h0) ? 3'h0 : 3'(1 << (fld[k] - 2'h1));
            chk("disch_sel", {5'h00, e}, {5'h00, sel[k]});
        end
    endtask

    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic       v;
        u_rdd_host_model.access(w, a, d, r, v);
        if (w)
            mdl_wr(a, d);
        chk("rdata_valid", {7'h00, ~w}, {7'h00, v});
        if (!w)
            chk("rdata", exp_rd(a), r);
        chk_out();
    endtask

    task automatic do_reset();
        srst_i = 1'b1;
        st_en  = 2'($urandom);
        straps = 24'($urandom);
        u_rdd_host_model.idle();
        repeat (10) @(negedge clk_i);
        srst_i = 1'b0;
        @(negedge clk_i);
        for (int i = 0; i < 2; i++)
            ctl[i] = {4'h0, 4'hF} << 2 | {7'h00, st_en[i]};
        for (int k = 0; k < 11; k++)
            fld[k] = straps[2*k +: 2];
        clr();
        foreach (addrs[i])
            acc(1'b0, addrs[i], 8'h00);
    endtask

    task automatic stop_test();
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Cuts a hang short; the whole sequence needs well under a thousand cycles.
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            fail_count++;
            stop_test();
        end
    end

    initial
    begin
        logic [7:0] a;
        logic [7:0] d;
        void'($urandom(61));
        rails = 12'h000;
        pins  = 2'b00;
        do_reset();
        for (int c = 0; c < 4; c++)
            for (int i = 0; i < 3; i++)
                acc(1'b1, 8'h40 + 8'(i), {4{2'(c)}});
        for (int n = 0; n < 80; n++)
        begin
            rails = 12'($urandom);
            pins  = 2'($urandom);
            a     = addrs[$urandom_range(6)];
            d     = 8'($urandom);
            if (a[7:1] == 7'h14)
                d[5:2] = 4'hF;
            clr();
            u_rdd_host_model.idle();
            acc(1'b1, a, d);
            acc(1'b0, a, 8'h00);
        end
        do_reset();
        stop_test();
    end
endmodule
